/* File: common/etc_consts.vh */
`ifndef ETC_CONSTS_VH
`define ETC_CONSTS_VH

// clock rate and documented times
`define ETC_CLK_KHZ          125000
`define ETC_REC_MS           150
`define ETC_REC_CYCLES       (`ETC_REC_MS * `ETC_CLK_KHZ)
`define ETC_STOP_MS          4
`define ETC_STOP_CYCLES      (`ETC_STOP_MS * `ETC_CLK_KHZ)
`define ETC_XTAL_DIV         8

// widths
`define ETC_CNT_W            44
`define ETC_SUB_W            12
`define ETC_ALM_W            32

// host byte offsets
`define ETC_OFF_SUB0         4'h0
`define ETC_OFF_SUB1         4'h1
`define ETC_OFF_SEC0         4'h2
`define ETC_OFF_SEC3         4'h5
`define ETC_OFF_ALM0         4'h6
`define ETC_OFF_ALM3         4'h9
`define ETC_OFF_CTLA         4'hA
`define ETC_OFF_CTLB         4'hB
`define ETC_OFF_STAT         4'hC

// control a fields
`define ETC_CA_REFRESH       7
`define ETC_CA_OSC_RUN       6
`define ETC_CA_SRC_HI        5
`define ETC_CA_SRC_LO        4
`define ETC_CA_EVT_POL       3
`define ETC_CA_SQWE          2
`define ETC_CA_PER_IEN       1
`define ETC_CA_ALM_IEN       0

// control b fields
`define ETC_CB_PRS_HI        7
`define ETC_CB_PRS_LO        4

// status fields
`define ETC_ST_STOPPED       7
`define ETC_ST_UIP           6
`define ETC_ST_PERIODIC      1
`define ETC_ST_ALARM         0

// count source encodings
`define ETC_SRC_PRIMARY      2'h0
`define ETC_SRC_BACKUP       2'h1

// reset values and the sync bit lane
`define ETC_CTLA_RST         8'hC0
`define ETC_CTLB_RST         8'h00
`define ETC_SUB0_LANE        0

`endif

/* File: dv/etc_core_assertions.sv */
`timescale 1ns/1ps
module etc_core_chk #(
  parameter integer REC_CYCLES = 20,
  parameter integer STOP_CYCLES = 40
) (
  input wire       ref_clk,
  input wire       sys_rst,
  input wire       cs_n,
  input wire       oe_n,
  input wire       we_n,
  input wire [3:0] address_lines,
  input wire [7:0] data_lines_in,
  input wire [7:0] data_lines_out,
  input wire       data_lines_oe,
  input wire       primary_power_ok,
  input wire       on_backup,
  input wire       event_gate_input,
  input wire       crystal_in,
  input wire       crystal_out,
  input wire       irq_out,
  input wire       irq_oe,
  input wire       bus_ready
);
  // recovery end window, counted after eight edges that must stay not ready
  localparam int RLO = REC_CYCLES - 10;
  localparam int RHI = REC_CYCLES - 6;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_read_drive;
    !cs_n && !oe_n && we_n && primary_power_ok |-> data_lines_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read cycle left data lines floating");
  property p_deselect;
    cs_n |-> !data_lines_oe;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("data driven while deselected");
  property p_pfail_float;
    !primary_power_ok |-> !data_lines_oe;
  endproperty
  a_pfail_float: assert property (p_pfail_float)
    else $error("data driven during power fail");
  property p_irq_low_only;
    irq_oe |-> irq_out == 1'b0;
  endproperty
  a_irq_low_only: assert property (p_irq_low_only)
    else $error("interrupt pin driven high");
  property p_rec_window;
    $fell(sys_rst) |-> !bus_ready [*8] ##[RLO:RHI] bus_ready;
  endproperty
  a_rec_window: assert property (p_rec_window)
    else $error("recovery interval length wrong");
  property p_ready_stays;
    bus_ready |=> bus_ready;
  endproperty
  a_ready_stays: assert property (p_ready_stays)
    else $error("bus ready dropped");
  property p_xtal_out;
    crystal_out |-> !$past(crystal_in);
  endproperty
  a_xtal_out: assert property (p_xtal_out)
    else $error("oscillator output not inverse of input");
  // no write now or on the previous edge means no flag can have been cleared
  property p_irq_sticky;
    irq_oe && (cs_n || we_n) && $past(cs_n || we_n) |=> irq_oe;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt released without a write");
  property p_no_drive_on_write;
    !we_n |-> !data_lines_oe;
  endproperty
  a_no_drive_on_write: assert property (p_no_drive_on_write)
    else $error("data driven during write");
endmodule

bind etc_core etc_core_chk #(.REC_CYCLES(REC_CYCLES), .STOP_CYCLES(STOP_CYCLES)) u_chk (
  .ref_clk, .sys_rst, .cs_n, .oe_n, .we_n, .address_lines, .data_lines_in,
  .data_lines_out, .data_lines_oe, .primary_power_ok, .on_backup,
  .event_gate_input, .crystal_in, .crystal_out, .irq_out, .irq_oe, .bus_ready
);

/* File: dv/etc_core_bench.sv */
`timescale 1ns/1ps
module etc_core_bench;
  localparam integer REC = 20;
  localparam integer STOP = 40;
  localparam [39:0] MODES = 40'hC0_E8E0_E0E8;
  localparam [4:0] EVT = 5'h0B;
  localparam [4:0] PWR = 5'h17;
  localparam [4:0] RUN = 5'h15;
  reg        ref_clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg        pwr_ok = 1'b1;
  reg        on_bk = 1'b0;
  reg        evt = 1'b0;
  reg        xtal = 1'b0;
  reg        xtal_run = 1'b1;
  reg  [2:0] xdiv = 3'h0;
  reg  [7:0] b;
  integer    fails = 0;
  integer    checks_done = 0;
  integer    cyc = 0;
  wire       cs_n, oe_n, we_n, doe, irq, irq_oe, rdy, xout;
  wire [3:0] adr;
  wire [7:0] din, dout;

  etc_host_model u_host (
    .ref_clk(ref_clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .address_lines(adr),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(doe)
  );
  etc_core #(.REC_CYCLES(REC), .STOP_CYCLES(STOP)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .address_lines(adr), .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(doe),
    .primary_power_ok(pwr_ok), .on_backup(on_bk), .event_gate_input(evt),
    .crystal_in(xtal), .crystal_out(xout), .irq_out(irq), .irq_oe(irq_oe), .bus_ready(rdy)
  );

  always #4 ref_clk = ~ref_clk;
  // crystal stand-in, ten clocks a period so a count takes 80 clocks, not 30000
  always @(posedge ref_clk) begin
    xdiv <= (xdiv == 3'h4) ? 3'h0 : xdiv + 3'h1;
    if (xdiv == 3'h4 && xtal_run)
      xtal <= ~xtal;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      end_of_test;
    end
  end

  task automatic chk(input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input [3:0] a, input [7:0] d);
    u_host.wr(a, d);
  endtask
  task automatic r(input [3:0] a);
    u_host.rd(a, b);
  endtask
  // counter lanes in byte order; low nibble of byte 0 written as zero
  task automatic set_cnt(input [47:0] v);
    integer i;
    for (i = 0; i < 6; i = i + 1)
      w(i[3:0], v[8*i +: 8]);
  endtask

  task automatic t_power_up;
    integer i;
    w(4'h6, 8'h5A);
    r(4'hA);
    chk(b, 8'hC0);
    chk(rdy, 1'b0);
    for (i = 0; i < 2 * REC && !rdy; i = i + 1)
      @(posedge ref_clk);
    chk(rdy, 1'b1);
    r(4'h6);
    chk(b, 8'h00);
  endtask
  // host copy frozen while refresh is off, then catches up
  task automatic t_count;
    w(4'hA, 8'h50);
    set_cnt({44'h123_4567_89F0, 4'h0});
    repeat (400) @(posedge ref_clk);
    r(4'h1);
    chk(b, 8'h9F);
    on_bk <= 1'b1;
    repeat (1920) @(posedge ref_clk);
    r(4'h1);
    chk(b, 8'h9F);
    r(4'hC);
    chk(b & 8'h40, 8'h40);
    w(4'hA, 8'hD0);
    r(4'h1);
    chk(b, 8'hA0);
    r(4'h5);
    chk(b, 8'h12);
    r(4'h2);
    chk(b, 8'h78);
    on_bk <= 1'b0;
  endtask
  task automatic t_modes;
    integer i;
    for (i = 0; i < 5; i = i + 1) begin
      w(4'hA, MODES[8*i +: 8]);
      set_cnt(48'h0000_0000_0000);
      evt <= EVT[i];
      pwr_ok <= PWR[i];
      repeat (1920) @(posedge ref_clk);
      pwr_ok <= 1'b1;
      r(4'h1);
      chk(b, {7'h00, RUN[i]});
    end
  endtask
  // counts on backup supply across the upper word boundary
  task automatic t_alarm;
    w(4'hA, 8'hD0);
    w(4'h6, 8'h01);
    w(4'h7, 8'h00);
    w(4'h8, 8'h00);
    w(4'h9, 8'h00);
    set_cnt({44'h000_0000_0FF8, 4'h0});
    w(4'hC, 8'h00);
    on_bk <= 1'b1;
    repeat (1600) @(posedge ref_clk);
    on_bk <= 1'b0;
    r(4'hC);
    chk(b & 8'h01, 8'h01);
    chk(irq_oe, 1'b0);
    w(4'hA, 8'hD1);
    // the interrupt enable is registered one edge after the control byte lands
    @(posedge ref_clk);
    chk(irq_oe, 1'b1);
    w(4'h6, 8'h02);
    w(4'hC, 8'h00);
    @(posedge ref_clk);
    chk(irq_oe, 1'b0);
  endtask
  task automatic t_periodic;
    w(4'hB, 8'h10);
    w(4'hA, 8'hD2);
    on_bk <= 1'b1;
    repeat (400) @(posedge ref_clk);
    on_bk <= 1'b0;
    r(4'hC);
    chk(b & 8'h03, 8'h02);
    chk(irq_oe, 1'b1);
    w(4'hB, 8'h00);
    w(4'hC, 8'h00);
    @(posedge ref_clk);
    chk(irq_oe, 1'b0);
    r(4'hC);
    chk(b & 8'h03, 8'h00);
  endtask
  task automatic t_pfail;
    pwr_ok <= 1'b0;
    w(4'h6, 8'hAA);
    pwr_ok <= 1'b1;
    r(4'h6);
    chk(b, 8'h02);
    w(4'h6, 8'hAA);
    r(4'h6);
    chk(b, 8'hAA);
  endtask
  // a short stall must not set the flag, a long one must
  task automatic t_osc_stop;
    w(4'hC, 8'h00);
    xtal_run <= 1'b0;
    repeat (10) @(posedge ref_clk);
    xtal_run <= 1'b1;
    r(4'hC);
    chk(b & 8'h80, 8'h00);
    xtal_run <= 1'b0;
    repeat (3 * STOP) @(posedge ref_clk);
    r(4'hC);
    chk(b & 8'h80, 8'h80);
    xtal_run <= 1'b1;
  endtask

  task end_of_test;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_power_up;
    t_count;
    t_modes;
    t_alarm;
    t_periodic;
    t_pfail;
    t_osc_stop;
    end_of_test;
  end
endmodule

/* File: dv/etc_host_model.sv */
`timescale 1ns/1ps
module etc_host_model (
  input  wire       ref_clk,
  output reg        cs_n = 1'b1,
  output reg        oe_n = 1'b1,
  output reg        we_n = 1'b1,
  output reg  [3:0] address_lines = 4'h0,
  output reg  [7:0] data_lines_in = 8'h00,
  input  wire [7:0] data_lines_out,
  input  wire       data_lines_oe
);
  // strobe low for one edge, then high again so each write is its own low period
  task automatic wr(input [3:0] a, input [7:0] d);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    we_n <= 1'b0;
    address_lines <= a;
    data_lines_in <= d;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    we_n <= 1'b1;
    data_lines_in <= ~d; // released bus must not keep the old byte
    @(posedge ref_clk);
  endtask
  // read byte is registered, so it is taken on the second edge
  task automatic rd(input [3:0] a, output [7:0] d);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    address_lines <= a;
    repeat (2) @(posedge ref_clk);
    d = data_lines_oe ? data_lines_out : ~data_lines_out; // floating bus reads wrong
    cs_n <= 1'b1;
    oe_n <= 1'b1;
  endtask
endmodule

/* File: rtl/etc_core.v */
`timescale 1ns/1ps
`include "etc_consts.vh"

module etc_core #(
  parameter integer REC_CYCLES = `ETC_REC_CYCLES,
  parameter integer STOP_CYCLES = `ETC_STOP_CYCLES
) (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       cs_n,
  input  wire       oe_n,
  input  wire       we_n,
  input  wire [3:0] address_lines,
  input  wire [7:0] data_lines_in,
  output reg  [7:0] data_lines_out,
  output wire       data_lines_oe,
  input  wire       primary_power_ok,
  input  wire       on_backup,
  input  wire       event_gate_input,
  input  wire       crystal_in,
  output reg        crystal_out,
  output wire       irq_out,
  output reg        irq_oe,
  output wire       bus_ready
);

  // periodic rate code to counter bit that must roll over
  function [5:0] etc_rate_bit;
    input [3:0] code;
    begin
      case (code)
        4'h1:    etc_rate_bit = 6'd0;
        4'h2:    etc_rate_bit = 6'd1;
        4'h3:    etc_rate_bit = 6'd2;
        4'h4:    etc_rate_bit = 6'd3;
        4'h5:    etc_rate_bit = 6'd4;
        4'h6:    etc_rate_bit = 6'd6;
        4'h7:    etc_rate_bit = 6'd8;
        4'h8:    etc_rate_bit = 6'd12;
        4'h9:    etc_rate_bit = 6'd16;
        4'hA:    etc_rate_bit = 6'd18;
        4'hB:    etc_rate_bit = 6'd20;
        4'hC:    etc_rate_bit = 6'd24;
        4'hD:    etc_rate_bit = 6'd28;
        4'hE:    etc_rate_bit = 6'd30;
        4'hF:    etc_rate_bit = 6'd33;
        default: etc_rate_bit = 6'd0;
      endcase
    end
  endfunction

  localparam [1:0] ST_RECOVER = 2'd0;
  localparam [1:0] ST_READY   = 2'd1;

  reg  [43:0] run_q;
  reg  [43:0] run_d;
  reg  [43:0] vis_q;
  reg  [43:0] vis_d;
  reg  [31:0] alarm_q;
  reg  [7:0]  ctla_q;
  reg  [7:0]  ctlb_q;
  reg         sqws_q;
  reg         osc_stopped_flag_q;
  reg         periodic_flag_q;
  reg         alarm_flag_q;
  reg  [1:0]  state_q;
  reg  [24:0] rec_q;
  reg         wr_q;
  reg         ev_s1_q;
  reg         ev_s2_q;
  reg         bk_s1_q;
  reg         bk_s2_q;
  reg         count_en;
  reg  [47:0] wbuf;
  reg  [7:0]  rd_byte;
  reg  [3:0]  byte_idx;
  integer     i;

  wire        tick;
  wire        osc_stop;
  wire        inc;
  wire [43:0] run_inc;
  wire [43:0] rate_mask;
  wire [5:0]  rate_bit;
  wire        wr_act;
  wire        wr_go;
  wire        rd_sel;
  wire        alarm_hit;
  wire        periodic_hit;
  wire        evt_active;
  wire [1:0]  src_sel;
  wire        is_cnt_addr;
  wire [47:0] vis_bytes;

  // crystal sampling, divide by eight and stop watchdog
  etc_timebase #(
    .STOP_CYCLES (STOP_CYCLES)
  ) u_timebase (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .crystal_in  (crystal_in),
    .osc_enable  (ctla_q[`ETC_CA_OSC_RUN]),
    .count_tick  (tick),
    .osc_stopped (osc_stop)
  );

  // feedback drive is the registered inverse of the crystal input; held low while the oscillator is off
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      crystal_out <= 1'b0;
    else
      crystal_out <= ctla_q[`ETC_CA_OSC_RUN] & ~crystal_in;
  end

  // power-up recovery: skipped when the oscillator is off at release
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_RECOVER;
      rec_q   <= 25'h000_0000;
    end else begin
      case (state_q)
        ST_RECOVER: begin
          if (!ctla_q[`ETC_CA_OSC_RUN])
            state_q <= ST_READY;
          else if (rec_q >= REC_CYCLES[24:0] - 25'h000_0001)
            state_q <= ST_READY;
          else
            rec_q <= rec_q + 25'h000_0001;
        end
        ST_READY: state_q <= ST_READY;
        default:  state_q <= ST_RECOVER;
      endcase
    end
  end

  assign bus_ready = (state_q == ST_READY);

  // a write is taken once, on the first cycle of a chip-select and write-enable low
  assign wr_act = ~cs_n & ~we_n & primary_power_ok & bus_ready;
  assign wr_go  = wr_act & ~wr_q;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      wr_q <= 1'b0;
    else
      wr_q <= wr_act;
  end

  // drive only for a real read with primary power; recovery does not gate it
  assign rd_sel        = ~cs_n & ~oe_n & we_n & primary_power_ok;
  assign data_lines_oe = rd_sel;

  // two-stage synchronisers; only the second stage is looked at
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      bk_s1_q <= 1'b0;
      bk_s2_q <= 1'b0;
    end else begin
      ev_s1_q <= event_gate_input;
      ev_s2_q <= ev_s1_q;
      bk_s1_q <= on_backup;
      bk_s2_q <= bk_s1_q;
    end
  end

  // count condition chosen by the source field
  assign src_sel    = ctla_q[`ETC_CA_SRC_HI:`ETC_CA_SRC_LO];
  assign evt_active = ~(ev_s2_q ^ ctla_q[`ETC_CA_EVT_POL]);

  always @* begin
    case (src_sel)
      `ETC_SRC_PRIMARY: count_en = ~bk_s2_q;
      `ETC_SRC_BACKUP:  count_en = bk_s2_q;
      default:          count_en = evt_active & primary_power_ok;
    endcase
  end

  assign inc     = tick & count_en;
  assign run_inc = run_q + 44'h000_0000_0001;

  // periodic roll-over test on the value just reached
  assign rate_bit  = etc_rate_bit(ctlb_q[`ETC_CB_PRS_HI:`ETC_CB_PRS_LO]);
  assign rate_mask = ~({44{1'b1}} << rate_bit);
  assign periodic_hit = inc && (ctlb_q[`ETC_CB_PRS_HI:`ETC_CB_PRS_LO] != 4'h0) &&
                        ((run_inc & rate_mask) == 44'h000_0000_0000);

  // upper 32 bits against alarm; runs whatever the supply
  assign alarm_hit = (run_q[43:12] == alarm_q);

  assign is_cnt_addr = (address_lines <= `ETC_OFF_SEC3);

  // counter next value: increment, then a host byte write overrides its lane
  always @* begin
    run_d = inc ? run_inc : run_q;
    wbuf  = {run_d, 4'h0};
    if (wr_go && is_cnt_addr) begin
      for (i = 0; i < 6; i = i + 1) begin
        if (address_lines == i[3:0])
          wbuf[i*8 +: 8] = data_lines_in;
      end
      run_d = wbuf[47:4];
    end
  end

  // host copy follows the running copy while refresh is on, and on any counter byte write
  always @* begin
    if (ctla_q[`ETC_CA_REFRESH] || (wr_go && is_cnt_addr))
      vis_d = run_d;
    else
      vis_d = vis_q;
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 44'h000_0000_0000;
      vis_q <= 44'h000_0000_0000;
    end else begin
      run_q <= run_d;
      vis_q <= vis_d;
    end
  end

  // plain control and alarm bytes
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_q <= 32'h0000_0000;
      ctla_q  <= `ETC_CTLA_RST;
      ctlb_q  <= `ETC_CTLB_RST;
      sqws_q  <= 1'b0;
    end else if (wr_go) begin
      case (address_lines)
        `ETC_OFF_SUB0: sqws_q <= data_lines_in[`ETC_SUB0_LANE];
        4'h6:          alarm_q[7:0]   <= data_lines_in;
        4'h7:          alarm_q[15:8]  <= data_lines_in;
        4'h8:          alarm_q[23:16] <= data_lines_in;
        `ETC_OFF_ALM3: alarm_q[31:24] <= data_lines_in;
        `ETC_OFF_CTLA: ctla_q <= data_lines_in;
        `ETC_OFF_CTLB: ctlb_q <= data_lines_in;
        default:       sqws_q <= sqws_q;
      endcase
    end
  end

  // sticky flags: hardware set wins over a host write of zero
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_stopped_flag_q <= 1'b0;
      periodic_flag_q    <= 1'b0;
      alarm_flag_q       <= 1'b0;
    end else begin
      if (osc_stop)
        osc_stopped_flag_q <= 1'b1;
      else if (wr_go && address_lines == `ETC_OFF_STAT && !data_lines_in[`ETC_ST_STOPPED])
        osc_stopped_flag_q <= 1'b0;
      if (periodic_hit)
        periodic_flag_q <= 1'b1;
      else if (wr_go && address_lines == `ETC_OFF_STAT && !data_lines_in[`ETC_ST_PERIODIC])
        periodic_flag_q <= 1'b0;
      if (alarm_hit)
        alarm_flag_q <= 1'b1;
      else if (wr_go && address_lines == `ETC_OFF_STAT && !data_lines_in[`ETC_ST_ALARM])
        alarm_flag_q <= 1'b0;
    end
  end

  // open drain: only ever pulls low, enable follows the masked flags
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      irq_oe <= 1'b0;
    else
      irq_oe <= (alarm_flag_q & ctla_q[`ETC_CA_ALM_IEN]) |
                (periodic_flag_q & ctla_q[`ETC_CA_PER_IEN]);
  end

  assign irq_out = 1'b0;

  // read mux; the low nibble of the first fraction byte carries the sync bit
  assign vis_bytes = {vis_q, 4'h0};

  always @* begin
    byte_idx = address_lines;
    rd_byte  = 8'h00;
    case (address_lines)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
        rd_byte = vis_bytes[byte_idx*8 +: 8];
      4'h6: rd_byte = alarm_q[7:0];
      4'h7: rd_byte = alarm_q[15:8];
      4'h8: rd_byte = alarm_q[23:16];
      4'h9: rd_byte = alarm_q[31:24];
      `ETC_OFF_CTLA: rd_byte = ctla_q;
      `ETC_OFF_CTLB: rd_byte = ctlb_q;
      `ETC_OFF_STAT: begin
        rd_byte[`ETC_ST_STOPPED]  = osc_stopped_flag_q;
        rd_byte[`ETC_ST_UIP]      = (vis_q != run_q);
        rd_byte[`ETC_ST_PERIODIC] = periodic_flag_q;
        rd_byte[`ETC_ST_ALARM]    = alarm_flag_q;
      end
      default: rd_byte = 8'h00;
    endcase
    if (address_lines == `ETC_OFF_SUB0)
      rd_byte[`ETC_SUB0_LANE] = sqws_q;
  end

  // read data out of a flop, one cycle behind the address
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      data_lines_out <= 8'h00;
    else
      data_lines_out <= rd_byte;
  end

endmodule

/* File: rtl/etc_timebase.v */
`timescale 1ns/1ps
`include "etc_consts.vh"

module etc_timebase #(
  parameter integer STOP_CYCLES = `ETC_STOP_CYCLES
) (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire crystal_in,
  input  wire osc_enable,
  output reg  count_tick,
  output reg  osc_stopped
);

  reg        xtal_q;
  reg [2:0]  div_q;
  reg [19:0] idle_q;
  wire       xtal_rise = crystal_in & ~xtal_q;

  // divide crystal rising edges by eight into one count enable
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_q     <= 1'b0;
      div_q      <= 3'h0;
      count_tick <= 1'b0;
    end else begin
      xtal_q     <= crystal_in;
      count_tick <= 1'b0;
      if (xtal_rise && osc_enable) begin
        div_q <= div_q + 3'h1;
        if (div_q == 3'h7)
          count_tick <= 1'b1;
      end
    end
  end

  // watchdog on crystal edges; a disabled oscillator also counts as stopped
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_q      <= 20'h0_0000;
      osc_stopped <= 1'b0;
    end else if (xtal_rise && osc_enable) begin
      idle_q      <= 20'h0_0000;
      osc_stopped <= 1'b0;
    end else if (idle_q >= STOP_CYCLES[19:0] - 20'h0_0001) begin
      osc_stopped <= 1'b1;
    end else begin
      idle_q <= idle_q + 20'h0_0001;
    end
  end

endmodule
